// ===== src/ses_pkg.sv
package ses_pkg;
    // Code-groups between forced idle sequences
    localparam int unsigned IDLE_CG_PERIOD = 5000;
    // Arbitration mode codes
    localparam logic [1:0] ARB_FCFS = 2'h0;
    localparam logic [1:0] ARB_SP1 = 2'h1;
    localparam logic [1:0] ARB_SP2 = 2'h2;
    // Egress code-group kinds
    localparam logic [1:0] TX_FILL = 2'h0;
    localparam logic [1:0] TX_IDLE = 2'h1;
    localparam logic [1:0] TX_PKT = 2'h2;
    // Admission watermarks, total packets held
    localparam logic [3:0] WM_ALL = 4'h8;
    localparam logic [3:0] WM_HP_P0 = 4'h2;
    localparam logic [3:0] WM_HP_P1 = 4'h4;
    localparam logic [3:0] WM_HP_P2 = 4'h6;
    localparam logic [3:0] WM_FAIR_P0 = 4'h5;
    localparam logic [3:0] WM_FAIR_P1 = 4'h6;
    localparam logic [3:0] WM_FAIR_P2 = 4'h7;
    // APB map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_PCNT0 = 8'h08;
    localparam logic [7:0] ADDR_PCNT1 = 8'h0C;
    localparam logic [7:0] ADDR_PCNT2 = 8'h10;
    localparam logic [7:0] ADDR_PCNT3 = 8'h14;
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_HP_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam int STAT_BUSY_LSB = 8;
    typedef enum logic {EG_READY, EG_WAIT} ses_eg_state_type;
endpackage

// ===== src/ses_egress_sched.sv
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module ses_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    assign in_ready = count_reg != (AW+1)'(DEPTH);
    assign out_valid = count_reg != '0;
    assign out_data = mem[rd_ptr_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers wrap naturally, so DEPTH must be a power of two
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_reg + AW'(push);
            rd_ptr_reg <= rd_ptr_reg + AW'(pop);
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// Function
// - Egress arbiter offers first-come-first-served and two strict priority modes.
// - First-come mode sends the longest-waiting packet first.
// - After a retry, send oldest highest-priority packet, then oldest again.
// - High-priority watermarks admit at most 6, 4, 2 packets for priorities 2, 1, 0.
// - Ingress retries a packet when the buffer is full for its priority.
// - Each egress inserts an idle sequence every 5000 code-groups.
// - Egress with nothing to send emits filler, distinct from idle.
// - Multicast input accepts one packet per cycle from one or several ingress ports.
// - Slow multicast egress causes ingress retries while it keeps full rate.
// - Multicast copies leave each destination port independently.
// - Fabric arbitration grants every ingress port its fair bandwidth share.
// - One ingress feeding several egress ports splits by egress drain rates.
// - Higher priority packets overtake lower ones in the same buffer.
// - Retried packets are excluded from per-priority sent counts.
module ses_egress_sched #(
    parameter int NUM_IN = 4,
    parameter int NUM_OUT = 2,
    parameter int BUF_DEPTH = 8,
    parameter int DATA_W = 32,
    parameter int FIFO_DEPTH = 32,
    parameter int IDLE_PERIOD = ses_pkg::IDLE_CG_PERIOD
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Ingress ports
    input wire logic [NUM_IN-1:0] in_valid,
    input wire logic [2*NUM_IN-1:0] in_prio,
    input wire logic [NUM_OUT*NUM_IN-1:0] in_dest,
    input wire logic [DATA_W*NUM_IN-1:0] in_data,
    output logic [NUM_IN-1:0] in_accept,
    output logic [NUM_IN-1:0] in_retry,
    // Egress links
    output logic [2*NUM_OUT-1:0] tx_kind,
    output logic [DATA_W*NUM_OUT-1:0] tx_data,
    input wire logic [NUM_OUT-1:0] tx_ack,
    input wire logic [NUM_OUT-1:0] tx_retry
);
    localparam int IW = $clog2(BUF_DEPTH);
    localparam int NIW = $clog2(NUM_IN);
    localparam int EW = 2 + NUM_OUT + DATA_W;
    localparam int CGW = $clog2(IDLE_PERIOD);

    logic [2:0] ctrl_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic [31:0] rd_val;
    logic rd_hit;
    logic [31:0] pcnt_reg [4];
    logic [31:0] pcnt_inc [4];
    logic [3:0] held_cnt_reg;
    logic [NIW-1:0] rr_reg;
    logic gnt_any;
    logic [NIW-1:0] gnt_idx;
    logic [1:0] gnt_prio;
    logic admit;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [EW-1:0] fifo_out_data;
    logic alloc_any;
    logic [IW-1:0] alloc_idx;
    logic alloc;
    logic ent_vld_reg [BUF_DEPTH];
    logic [1:0] ent_prio_reg [BUF_DEPTH];
    logic [NUM_OUT-1:0] ent_dest_reg [BUF_DEPTH];
    logic [DATA_W-1:0] ent_data_reg [BUF_DEPTH];
    logic [IW-1:0] ent_rank_reg [BUF_DEPTH];
    logic [IW-1:0] rank_next [BUF_DEPTH];
    logic [NUM_OUT-1:0] clr [BUF_DEPTH];
    logic [BUF_DEPTH-1:0] free;
    logic [3:0] num_free;
    logic [IW:0] survivors;
    ses_pkg::ses_eg_state_type eg_state_reg [NUM_OUT];
    logic alt_reg [NUM_OUT];
    logic [IW-1:0] infl_reg [NUM_OUT];
    logic [CGW-1:0] cg_cnt_reg [NUM_OUT];
    logic [1:0] tx_kind_reg [NUM_OUT];
    logic [DATA_W-1:0] tx_data_reg [NUM_OUT];
    logic pick_any [NUM_OUT];
    logic [IW-1:0] pick_idx [NUM_OUT];
    logic [NUM_OUT-1:0] ack_ok;
    logic [NUM_OUT-1:0] rty_ok;
    logic [NUM_OUT-1:0] idle_slot;
    logic [NUM_OUT-1:0] go;
    logic [NUM_OUT-1:0] busy;
    logic [1:0] mode;

    function automatic logic [3:0] wm_limit(input logic [1:0] prio, input logic hp);
        case (prio)
            2'h0: wm_limit = hp ? ses_pkg::WM_HP_P0 : ses_pkg::WM_FAIR_P0;
            2'h1: wm_limit = hp ? ses_pkg::WM_HP_P1 : ses_pkg::WM_FAIR_P1;
            2'h2: wm_limit = hp ? ses_pkg::WM_HP_P2 : ses_pkg::WM_FAIR_P2;
            default: wm_limit = ses_pkg::WM_ALL;
        endcase
    endfunction

    // One wait state so read data comes from a flop
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign prdata = prdata_reg;
    assign mode = ctrl_reg[ses_pkg::CTRL_MODE_LSB +: 2];

    always_comb begin
        rd_hit = 1'b1;
        rd_val = '0;
        if (paddr == ses_pkg::ADDR_CTRL) begin
            rd_val = {29'h0, ctrl_reg};
        end else if (paddr == ses_pkg::ADDR_STATUS) begin
            rd_val[3:0] = held_cnt_reg;
            rd_val[ses_pkg::STAT_BUSY_LSB +: NUM_OUT] = busy;
        end else if (paddr == ses_pkg::ADDR_PCNT0) begin
            rd_val = pcnt_reg[0];
        end else if (paddr == ses_pkg::ADDR_PCNT1) begin
            rd_val = pcnt_reg[1];
        end else if (paddr == ses_pkg::ADDR_PCNT2) begin
            rd_val = pcnt_reg[2];
        end else if (paddr == ses_pkg::ADDR_PCNT3) begin
            rd_val = pcnt_reg[3];
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= '0;
        end else begin
            pready_reg <= psel && penable && !pready_reg;
            pslverr_reg <= psel && penable && !pready_reg && !rd_hit;
            prdata_reg <= (psel && penable && !pready_reg && !pwrite) ? rd_val : '0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= ses_pkg::CTRL_RESET;
        end else if (psel && penable && pready_reg && pwrite && paddr == ses_pkg::ADDR_CTRL) begin
            ctrl_reg <= pwdata[2:0];
        end
    end

    // Round robin over ingress ports, one decision per cycle
    always_comb begin
        int idx;
        idx = 0;
        gnt_any = 1'b0;
        gnt_idx = '0;
        for (int k = 0; k < NUM_IN; k++) begin
            idx = (int'(rr_reg) + k) % NUM_IN;
            if (!gnt_any && in_valid[idx]) begin
                gnt_any = 1'b1;
                gnt_idx = NIW'(idx);
            end
        end
        gnt_prio = in_prio[gnt_idx*2 +: 2];
        admit = gnt_any && fifo_in_ready && held_cnt_reg < wm_limit(gnt_prio, ctrl_reg[ses_pkg::CTRL_HP_BIT]);
        in_accept = '0;
        in_retry = '0;
        in_accept[gnt_idx] = admit;
        in_retry[gnt_idx] = gnt_any && !admit;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rr_reg <= '0;
        end else if (gnt_any) begin
            rr_reg <= (gnt_idx == NIW'(NUM_IN - 1)) ? '0 : gnt_idx + 1'b1;
        end
    end

    ses_fifo #(.W(EW), .DEPTH(FIFO_DEPTH)) ses_fifo_inst (
        .clk(ref_clk),
        .rst(rst),
        .in_valid(admit),
        .in_data({gnt_prio, in_dest[gnt_idx*NUM_OUT +: NUM_OUT], in_data[gnt_idx*DATA_W +: DATA_W]}),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(alloc_any)
    );

    // Slot bookkeeping; rank 0 is the oldest packet held
    always_comb begin
        int dec;
        int nf;
        int sv;
        dec = 0;
        nf = 0;
        sv = 0;
        alloc_any = 1'b0;
        alloc_idx = '0;
        for (int i = 0; i < BUF_DEPTH; i++) begin
            if (!alloc_any && !ent_vld_reg[i]) begin
                alloc_any = 1'b1;
                alloc_idx = IW'(i);
            end
            for (int p = 0; p < NUM_OUT; p++) begin
                clr[i][p] = ack_ok[p] && infl_reg[p] == IW'(i);
            end
            free[i] = ent_vld_reg[i] && |clr[i] && (ent_dest_reg[i] & ~clr[i]) == '0;
        end
        for (int i = 0; i < BUF_DEPTH; i++) begin
            dec = 0;
            for (int j = 0; j < BUF_DEPTH; j++) begin
                if (free[j] && ent_rank_reg[j] < ent_rank_reg[i]) begin
                    dec = dec + 1;
                end
            end
            rank_next[i] = IW'(int'(ent_rank_reg[i]) - dec);
            nf = nf + int'(free[i]);
            sv = sv + int'(ent_vld_reg[i] && !free[i]);
        end
        num_free = 4'(nf);
        survivors = (IW+1)'(sv);
    end
    assign alloc = fifo_out_valid && alloc_any;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            held_cnt_reg <= '0;
            for (int i = 0; i < BUF_DEPTH; i++) begin
                ent_vld_reg[i] <= 1'b0;
                ent_prio_reg[i] <= '0;
                ent_dest_reg[i] <= '0;
                ent_data_reg[i] <= '0;
                ent_rank_reg[i] <= '0;
            end
        end else begin
            held_cnt_reg <= 4'(int'(held_cnt_reg) + int'(admit) - int'(num_free));
            for (int i = 0; i < BUF_DEPTH; i++) begin
                if (alloc && alloc_idx == IW'(i)) begin
                    // Eligible for egress on the next cycle
                    ent_vld_reg[i] <= 1'b1;
                    {ent_prio_reg[i], ent_dest_reg[i], ent_data_reg[i]} <= fifo_out_data;
                    ent_rank_reg[i] <= IW'(survivors);
                end else begin
                    ent_vld_reg[i] <= ent_vld_reg[i] && !free[i];
                    ent_dest_reg[i] <= ent_dest_reg[i] & ~clr[i];
                    ent_rank_reg[i] <= rank_next[i];
                end
            end
        end
    end

    genvar gp;
    generate
        for (gp = 0; gp < NUM_OUT; gp++) begin : g_eg
            assign ack_ok[gp] = eg_state_reg[gp] == ses_pkg::EG_WAIT && tx_ack[gp];
            assign rty_ok[gp] = eg_state_reg[gp] == ses_pkg::EG_WAIT && tx_retry[gp];
            assign idle_slot[gp] = cg_cnt_reg[gp] == CGW'(IDLE_PERIOD - 1);
            assign go[gp] = eg_state_reg[gp] == ses_pkg::EG_READY && pick_any[gp] && !idle_slot[gp];
            assign busy[gp] = eg_state_reg[gp] == ses_pkg::EG_WAIT;
            assign tx_kind[gp*2 +: 2] = tx_kind_reg[gp];
            assign tx_data[gp*DATA_W +: DATA_W] = tx_data_reg[gp];

            // Each port picks from the shared buffer on its own drain rate
            always_comb begin
                logic use_prio;
                logic by_rank;
                logic better;
                use_prio = mode == ses_pkg::ARB_SP1 || mode == ses_pkg::ARB_SP2 || alt_reg[gp];
                by_rank = mode != ses_pkg::ARB_SP1 || alt_reg[gp];
                better = 1'b0;
                pick_any[gp] = 1'b0;
                pick_idx[gp] = '0;
                for (int i = 0; i < BUF_DEPTH; i++) begin
                    if (ent_vld_reg[i] && ent_dest_reg[i][gp]) begin
                        if (use_prio && ent_prio_reg[i] != ent_prio_reg[pick_idx[gp]]) begin
                            better = ent_prio_reg[i] > ent_prio_reg[pick_idx[gp]];
                        end else begin
                            better = by_rank && ent_rank_reg[i] < ent_rank_reg[pick_idx[gp]];
                        end
                        if (!pick_any[gp] || better) begin
                            pick_idx[gp] = IW'(i);
                        end
                        pick_any[gp] = 1'b1;
                    end
                end
            end

            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    cg_cnt_reg[gp] <= '0;
                    tx_kind_reg[gp] <= ses_pkg::TX_FILL;
                    tx_data_reg[gp] <= '0;
                end else begin
                    cg_cnt_reg[gp] <= idle_slot[gp] ? '0 : cg_cnt_reg[gp] + 1'b1;
                    tx_data_reg[gp] <= go[gp] ? ent_data_reg[pick_idx[gp]] : '0;
                    if (idle_slot[gp]) begin
                        tx_kind_reg[gp] <= ses_pkg::TX_IDLE;
                    end else if (go[gp]) begin
                        tx_kind_reg[gp] <= ses_pkg::TX_PKT;
                    end else begin
                        tx_kind_reg[gp] <= ses_pkg::TX_FILL;
                    end
                end
            end

            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    eg_state_reg[gp] <= ses_pkg::EG_READY;
                    infl_reg[gp] <= '0;
                    alt_reg[gp] <= 1'b0;
                end else begin
                    case (eg_state_reg[gp])
                        ses_pkg::EG_READY: begin
                            if (go[gp]) begin
                                eg_state_reg[gp] <= ses_pkg::EG_WAIT;
                                infl_reg[gp] <= pick_idx[gp];
                                alt_reg[gp] <= 1'b0;
                            end
                        end
                        default: begin
                            if (ack_ok[gp] || rty_ok[gp]) begin
                                eg_state_reg[gp] <= ses_pkg::EG_READY;
                            end
                            if (rty_ok[gp]) begin
                                alt_reg[gp] <= 1'b1;
                            end
                        end
                    endcase
                end
            end
        end
    endgenerate

    // Only acknowledged copies are counted
    always_comb begin
        for (int q = 0; q < 4; q++) begin
            pcnt_inc[q] = '0;
            for (int p = 0; p < NUM_OUT; p++) begin
                if (ack_ok[p] && ent_prio_reg[infl_reg[p]] == 2'(q)) begin
                    pcnt_inc[q] = pcnt_inc[q] + 32'h1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int q = 0; q < 4; q++) begin
                pcnt_reg[q] <= '0;
            end
        end else begin
            for (int q = 0; q < 4; q++) begin
                pcnt_reg[q] <= pcnt_reg[q] + pcnt_inc[q];
            end
        end
    end

    // Checks on egress port 0, ingress admission and the held and sent counts
    logic order_ok0;
    always_comb begin
        order_ok0 = 1'b1;
        for (int i = 0; i < BUF_DEPTH; i++) begin
            if (ent_vld_reg[i] && ent_dest_reg[i][0]) begin
                if ((mode != ses_pkg::ARB_FCFS || alt_reg[0]) && ent_prio_reg[i] > ent_prio_reg[pick_idx[0]]) begin
                    order_ok0 = 1'b0;
                end
                if (mode == ses_pkg::ARB_FCFS && !alt_reg[0] && ent_rank_reg[i] < ent_rank_reg[pick_idx[0]]) begin
                    order_ok0 = 1'b0;
                end
            end
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    AST_PICK_ORDER: assert property (go[0] |-> order_ok0)
        else $error("egress 0 picked out of order");
    AST_SP_TOP: assert property (go[0] && mode == ses_pkg::ARB_SP2 |-> order_ok0)
        else $error("strict priority skipped a higher priority");
    AST_RETRY_ALT: assert property (rty_ok[0] |=> alt_reg[0] && eg_state_reg[0] == ses_pkg::EG_READY)
        else $error("retry did not arm the priority pick");
    AST_ALT_ONCE: assert property (go[0] && alt_reg[0] |=> !alt_reg[0] && busy[0])
        else $error("priority pick not followed by oldest again");
    AST_WM_ADMIT: assert property (|in_accept |-> held_cnt_reg < wm_limit(gnt_prio, ctrl_reg[ses_pkg::CTRL_HP_BIT]))
        else $error("packet admitted above its watermark");
    AST_HELD_MAX: assert property (held_cnt_reg <= ses_pkg::WM_ALL)
        else $error("held packets exceed capacity");
    AST_RETRY_FULL: assert property (|in_retry |-> !fifo_in_ready || held_cnt_reg >= wm_limit(gnt_prio, ctrl_reg[ses_pkg::CTRL_HP_BIT]))
        else $error("retry issued with room left");
    AST_IDLE_INSERT: assert property (idle_slot[0] |=> tx_kind_reg[0] == ses_pkg::TX_IDLE && cg_cnt_reg[0] == '0)
        else $error("idle sequence not inserted");
    AST_FILLER: assert property (eg_state_reg[0] == ses_pkg::EG_READY && !pick_any[0] && !idle_slot[0] |=> tx_kind_reg[0] == ses_pkg::TX_FILL)
        else $error("filler missing on empty egress");
    AST_ONE_GRANT: assert property ($onehot0(in_accept | in_retry) && (gnt_any == |(in_accept | in_retry)))
        else $error("ingress grant not one-hot");
    AST_MCAST_INDEP: assert property (ack_ok[0] |=> !ent_dest_reg[$past(infl_reg[0])][0])
        else $error("multicast copy not released for port 0");
    AST_NO_RETRY_COUNT: assert property (ack_ok == '0 |=> $stable(pcnt_reg[0]) && $stable(pcnt_reg[1]) && $stable(pcnt_reg[2]) && $stable(pcnt_reg[3]))
        else $error("count moved without an acknowledge");

    COV_INGRESS_RETRY: cover property (|in_retry);
    COV_IDLE: cover property (tx_kind_reg[0] == ses_pkg::TX_IDLE);
    COV_ALT_PICK: cover property (rty_ok[0] ##[1:20] (go[0] && alt_reg[0]));
    COV_MCAST: cover property (alloc && fifo_out_data[DATA_W +: NUM_OUT] == '1);
endmodule

`default_nettype wire

// ===== tb/ses_link_partner.sv
`timescale 1ns/1ps
`default_nettype none
module ses_link_partner #(
    parameter int N = 2
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Egress stream seen
    input wire logic [2*N-1:0] tx_kind,
    // Scenario control
    input wire logic [N-1:0] stall,
    input wire logic retry_en,
    // Answers
    output logic [N-1:0] tx_ack,
    output logic [N-1:0] tx_retry
);
    logic [N-1:0] pend_reg;
    logic [N-1:0] retried_reg;
    // Stall holds the answer back; with retry_en each port's answers alternate, a refusal and then an acceptance
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pend_reg <= '0;
            retried_reg <= '0;
            tx_ack <= '0;
            tx_retry <= '0;
        end else begin
            for (int p = 0; p < N; p++) begin
                tx_ack[p] <= 1'b0;
                tx_retry[p] <= 1'b0;
                if (tx_kind[2*p+:2] == ses_pkg::TX_PKT) begin
                    pend_reg[p] <= 1'b1;
                end else if (pend_reg[p] && !stall[p]) begin
                    pend_reg[p] <= 1'b0;
                    tx_retry[p] <= retry_en && !retried_reg[p];
                    tx_ack[p] <= !(retry_en && !retried_reg[p]);
                    retried_reg[p] <= retry_en && !retried_reg[p];
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/switch_egress_scheduling_tb.sv
`timescale 1ns/1ps
`default_nettype none
module switch_egress_scheduling_tb;
    logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, retry_en = 0, pready, pslverr, err, acc;
    logic [7:0] paddr = 0, in_prio = 0, in_dest = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [3:0] in_valid = 0, in_accept, in_retry, tx_kind;
    logic [127:0] in_data = 0;
    logic [63:0] tx_data;
    logic [1:0] tx_ack, tx_retry, stall = 0;
    logic [31:0] q[$];
    logic [31:0] ex[4] = '{32'h1, 32'h3, 32'h4, 32'h2};
    logic [31:0] ex2[6] = '{32'h10, 32'h11, 32'h10, 32'h12, 32'h10, 32'h10};
    int n_errors = 0, num_checks = 0, cyc = 0, idles = 0, fills = 0, pk1 = 0, s0, s1;
    ses_egress_sched #(.IDLE_PERIOD(40)) ses_egress_sched_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .in_valid(in_valid), .in_prio(in_prio), .in_dest(in_dest), .in_data(in_data),
        .in_accept(in_accept), .in_retry(in_retry), .tx_kind(tx_kind), .tx_data(tx_data), .tx_ack(tx_ack),
        .tx_retry(tx_retry));
    ses_link_partner #(.N(2)) ses_link_partner_inst (.ref_clk(ref_clk), .rst(rst), .tx_kind(tx_kind),
        .stall(stall), .retry_en(retry_en), .tx_ack(tx_ack), .tx_retry(tx_retry));
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (tx_kind[1:0] === ses_pkg::TX_PKT) q.push_back(tx_data[31:0]);
        idles += (tx_kind[1:0] === ses_pkg::TX_IDLE);
        fills += (tx_kind[1:0] === ses_pkg::TX_FILL);
        pk1 += (tx_kind[3:2] === ses_pkg::TX_PKT);
        // Whole run needs well under a thousand cycles
        if (cyc == 3000) begin
            n_errors++;
            summarize();
        end
    end
    task chk(string nm, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task offer(int p, logic [1:0] pr, logic [1:0] ds, logic [31:0] d);
        @(posedge ref_clk);
        in_valid[p] <= 1;
        in_prio[2*p+:2] <= pr;
        in_dest[2*p+:2] <= ds;
        in_data[32*p+:32] <= d;
        do @(posedge ref_clk); while (in_accept[p] !== 1'b1 && in_retry[p] !== 1'b1);
        acc = in_accept[p];
        in_valid[p] <= 0;
    endtask
    task summarize();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 0;
        apb(0, ses_pkg::ADDR_CTRL, 0);
        chk("ctrl", {29'h0, ses_pkg::CTRL_RESET}, rd);
        apb(1, 8'h40, 32'hF);
        chk("unmapped", 32'h1, {31'h0, err});
        s0 = idles;
        s1 = fills;
        repeat (80) @(posedge ref_clk);
        chk("idles", 32'h2, 32'(idles - s0));
        chk("fills", 32'h4E, 32'(fills - s1));
        $display("test idle done");
        apb(1, ses_pkg::ADDR_CTRL, 32'h6);
        stall <= 2'h3;
        q.delete();
        offer(0, 0, 1, 1);
        chk("acc p0a", 1, acc);
        offer(0, 0, 1, 2);
        chk("acc p0b", 1, acc);
        offer(0, 0, 1, 9);
        chk("acc p0c", 0, acc);
        offer(0, 3, 1, 3);
        chk("acc p3", 1, acc);
        offer(0, 1, 1, 4);
        chk("acc p1", 1, acc);
        apb(0, ses_pkg::ADDR_STATUS, 0);
        chk("held", 32'h4, {28'h0, rd[3:0]});
        stall <= 0;
        repeat (40) @(posedge ref_clk);
        chk("count", 32'h4, q.size());
        foreach (ex[i]) chk("order", ex[i], q[i]);
        apb(0, ses_pkg::ADDR_PCNT0, 0);
        chk("pcnt0", 32'h2, rd);
        apb(0, ses_pkg::ADDR_PCNT3, 0);
        chk("pcnt3", 32'h1, rd);
        $display("test priority done");
        retry_en <= 1;
        offer(0, 2, 1, 5);
        repeat (20) @(posedge ref_clk);
        chk("resent", 32'h5, q[5]);
        apb(0, ses_pkg::ADDR_PCNT2, 0);
        chk("pcnt2", 32'h1, rd);
        retry_en <= 0;
        $display("test retry done");
        stall <= 2'h2;
        s1 = pk1;
        offer(0, 2, 2, 7);
        offer(0, 2, 3, 6);
        repeat (10) @(posedge ref_clk);
        chk("mc port0", 32'h6, q[6]);
        chk("mc port1 held", 32'h1, 32'(pk1 - s1));
        stall <= 0;
        repeat (20) @(posedge ref_clk);
        chk("mc port1", 32'h2, 32'(pk1 - s1));
        $display("test multicast done");
        // First-come mode: each refusal of the oldest lets the top priority through once
        apb(1, ses_pkg::ADDR_CTRL, 0);
        stall <= 2'h1;
        retry_en <= 1;
        offer(0, 0, 1, 32'h10);
        offer(0, 2, 1, 32'h11);
        offer(0, 1, 1, 32'h12);
        stall <= 0;
        repeat (60) @(posedge ref_clk);
        foreach (ex2[i]) chk("fcfs order", ex2[i], q[7+i]);
        chk("fcfs count", 32'hD, q.size());
        retry_en <= 0;
        $display("test fcfs done");
        summarize();
    end
endmodule
`default_nettype wire
